// >>> core/bto_cfg.svh
`ifndef BTO_CFG_SVH
`define BTO_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BTO_ADDR_CTRL 8'h00
`define BTO_ADDR_DIR 8'h04
`define BTO_ADDR_CELL_A 8'h08
`define BTO_ADDR_CELL_B 8'h0C
`define BTO_ADDR_STATUS 8'h10
`define BTO_ADDR_SHADOW 8'h14

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BTO_CTRL_OP 2:0
`define BTO_CTRL_MASK 10:3
`define BTO_CTRL_W 11
`define BTO_CTRL_RST 11'h000
`define BTO_DIR_RST 2'h3
`define BTO_CELL_RST 8'h00

// ----------------------------------------
// opcodes, feedback taps, bus answers
// ----------------------------------------
`define BTO_OPC_TOGGLE 2'h0
`define BTO_OPC_PRPG16 2'h1
`define BTO_OPC_PSA16 2'h2
`define BTO_OPC_CPAT 3'h3
`define BTO_OPC_CCNT 3'h7
`define BTO_TAP16 16'hB400
`define BTO_TAP8 8'hB8
`define BTO_RESP_OKAY 2'h0
`define BTO_RESP_SLVERR 2'h2

// ----------------------------------------
// synchroniser width: tck, tdi, four tap flags, sixteen pins
// ----------------------------------------
`define BTO_SYNC_W 22

`endif

// >>> core/bto_pkg.sv
package bto_pkg;

	// ----------------------------------------
	// decoded boundary test operation
	// ----------------------------------------
	typedef enum logic [4:0] {
		BTO_OP_TOGGLE = 5'b00001,
		BTO_OP_PRPG16 = 5'b00010,
		BTO_OP_PSA16 = 5'b00100,
		BTO_OP_CPAT = 5'b01000,
		BTO_OP_CCNT = 5'b10000
	} bto_op_t;

	// ----------------------------------------
	// side index of the transceiver pins
	// ----------------------------------------
	typedef enum logic {
		BTO_SIDE_A = 1'b0,
		BTO_SIDE_B = 1'b1
	} bto_side_t;

endpackage

// >>> core/bto_engine.sv
`timescale 1ns/1ps
`include "bto_cfg.svh"

// What this block does
// - opcode 011 runs 8-bit input signature plus 8-bit pseudo-random outputs.
// - opcode 111 runs 8-bit input signature plus 8-bit binary count outputs.
// - low bits 00 toggle, 01 16-bit pattern, 10 16-bit signature; bit 2 ignored.
// - operations run only with run-test instruction loaded and controller in idle.
// - direction cells stay out of algorithms; enables still drive or float outputs.
// - operations run only when exactly one direction enabled, else bypass.
// - control bits 10..3 mask receiving pins eight down to one.
// - mask one removes pin from signature; mask zero keeps it.
// - toggle mode captures receiving pins on rise, then copies to shadows.
// - toggle mode inverts output shift stages on rise, drives pins on fall.
// - pattern mode steps 16-bit lfsr on rise; shadows and pins follow on fall.
// - all-zero seed locks the generators; nothing special is done about it.
// - 16-bit signature folds receiving pins in on rise; input shadows follow.
// - during 16-bit signature output shadows hold and keep driving pins.
// - combined modes fold receiving pins into 8-bit signature on rise.
// - combined pattern mode steps 8-bit generator on rise, drives on fall.
// - combined count mode increments outputs as 8-bit counter, drives on fall.
// - opposite output cells count carries, extending the count to 16 bits.
// - serial data, tap flags and pins are sampled on the rising test clock.
// - serial output and pins change only on the falling test clock.
// - in shift states serial bits enter on input and leave on output.
module bto_engine (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic [7:0] AWADDR_I,
	input wire logic AWVALID_I,
	output logic AWREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic [3:0] WSTRB_I,
	input wire logic WVALID_I,
	output logic WREADY_O,
	output logic [1:0] BRESP_O,
	output logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic [7:0] ARADDR_I,
	input wire logic ARVALID_I,
	output logic ARREADY_O,
	output logic [31:0] RDATA_O,
	output logic [1:0] RRESP_O,
	output logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic TCK_I,
	input wire logic TDI_I,
	output logic TDO_O,
	input wire logic RUN_BOUNDARY_TEST_INSTRUCTION_I,
	input wire logic RUN_IDLE_I,
	input wire logic CAPTURE_DR_I,
	input wire logic SHIFT_DR_I,
	input wire logic [7:0] A_SIDE_PINS_I,
	input wire logic [7:0] B_SIDE_PINS_I,
	output logic [7:0] A_SIDE_PINS_O,
	output logic [7:0] B_SIDE_PINS_O,
	output logic A_SIDE_PINS_OE_N_O,
	output logic B_SIDE_PINS_OE_N_O,
	output logic [7:0] A_SIDE_LOGIC_O,
	output logic [7:0] B_SIDE_LOGIC_O
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [`BTO_SYNC_W-1:0] sync1_ff, sync2_ff;
	logic tck_d_ff, tck_rise, tck_fall;
	logic tdi_s, run_instr_s, run_idle_s, capture_s, shift_s;
	logic [7:0] pins_s [0:1];
	logic [`BTO_CTRL_W-1:0] ctrl_ff;
	logic [1:0] oe_n_ff;
	logic [7:0] in_sh_ff [0:1], out_sh_ff [0:1], in_shd_ff [0:1], out_shd_ff [0:1];
	logic step_pend_ff, bypass_ff, tdo_ff;
	logic one_dir, run_ok, step;
	bto_pkg::bto_side_t drv, rcv;
	bto_pkg::bto_op_t op;
	logic [7:0] rcv_pins, masked, nxt_in, nxt_out, nxt_carry;
	logic [15:0] chain, nxt_chain;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff, wr_merge, rd_word;
	logic [3:0] wstrb_ff;
	logic aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic do_write, wr_hit, rd_hit;

	// ----------------------------------------
	// test clock and pin synchronisers
	// ----------------------------------------
	// two stages on everything from the tap side; all taken from the same stage so one edge sees one
	// consistent snapshot of data, flags and pins
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {TCK_I, TDI_I, RUN_BOUNDARY_TEST_INSTRUCTION_I, RUN_IDLE_I, CAPTURE_DR_I,
				SHIFT_DR_I, B_SIDE_PINS_I, A_SIDE_PINS_I};
			sync2_ff <= sync1_ff;
		end
	end

	// edge finder on the synchronised test clock
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			tck_d_ff <= 1'b0;
		end else begin
			tck_d_ff <= sync2_ff[21];
		end
	end

	assign tck_rise = sync2_ff[21] & ~tck_d_ff;
	assign tck_fall = ~sync2_ff[21] & tck_d_ff;
	assign tdi_s = sync2_ff[20];
	assign run_instr_s = sync2_ff[19];
	assign run_idle_s = sync2_ff[18];
	assign capture_s = sync2_ff[17];
	assign shift_s = sync2_ff[16];
	assign pins_s[0] = sync2_ff[7:0];
	assign pins_s[1] = sync2_ff[15:8];

	// ----------------------------------------
	// run qualification and direction
	// ----------------------------------------
	// enable cells are active low; the side whose enable is low drives, the other receives
	assign one_dir = oe_n_ff[0] ^ oe_n_ff[1];
	assign drv = oe_n_ff[0] ? bto_pkg::BTO_SIDE_B : bto_pkg::BTO_SIDE_A;
	assign rcv = oe_n_ff[0] ? bto_pkg::BTO_SIDE_A : bto_pkg::BTO_SIDE_B;
	assign run_ok = run_instr_s & run_idle_s & one_dir;
	assign step = tck_rise & run_ok;
	assign rcv_pins = pins_s[rcv];
	assign masked = rcv_pins & ~ctrl_ff[`BTO_CTRL_MASK];

	// opcode decode; bit 2 only matters when the low bits are 11
	always_comb begin
		case (ctrl_ff[1:0])
			`BTO_OPC_TOGGLE: op = bto_pkg::BTO_OP_TOGGLE;
			`BTO_OPC_PRPG16: op = bto_pkg::BTO_OP_PRPG16;
			`BTO_OPC_PSA16: op = bto_pkg::BTO_OP_PSA16;
			default: begin
				if (ctrl_ff[`BTO_CTRL_OP] == `BTO_OPC_CCNT) begin
					op = bto_pkg::BTO_OP_CCNT;
				end else begin
					op = bto_pkg::BTO_OP_CPAT;
				end
			end
		endcase
	end

	// ----------------------------------------
	// algorithm next values
	// ----------------------------------------
	// driving cells form the upper half of the 16-bit chain; a zero seed stays zero, by design
	assign chain = {out_sh_ff[drv], in_sh_ff[rcv]};

	always_comb begin
		nxt_in = in_sh_ff[rcv];
		nxt_out = out_sh_ff[drv];
		nxt_carry = out_sh_ff[rcv];
		nxt_chain = {chain[14:0], ^(chain & `BTO_TAP16)};
		case (op)
			bto_pkg::BTO_OP_TOGGLE: begin
				nxt_in = rcv_pins;
				nxt_out = ~out_sh_ff[drv];
			end
			bto_pkg::BTO_OP_PRPG16: begin
				nxt_in = nxt_chain[7:0];
				nxt_out = nxt_chain[15:8];
			end
			bto_pkg::BTO_OP_PSA16: begin
				nxt_in = nxt_chain[7:0] ^ masked;
				nxt_out = nxt_chain[15:8];
			end
			bto_pkg::BTO_OP_CPAT: begin
				nxt_in = {in_sh_ff[rcv][6:0], ^(in_sh_ff[rcv] & `BTO_TAP8)} ^ masked;
				nxt_out = {out_sh_ff[drv][6:0], ^(out_sh_ff[drv] & `BTO_TAP8)};
			end
			bto_pkg::BTO_OP_CCNT: begin
				nxt_in = {in_sh_ff[rcv][6:0], ^(in_sh_ff[rcv] & `BTO_TAP8)} ^ masked;
				nxt_out = out_sh_ff[drv] + 8'h01;
				if (&out_sh_ff[drv]) begin
					nxt_carry = out_sh_ff[rcv] + 8'h01;
				end
			end
			default: begin
				nxt_in = in_sh_ff[rcv];
			end
		endcase
	end

	// ----------------------------------------
	// boundary cells, one set per side
	// ----------------------------------------
	generate
		for (genvar s = 0; s < 2; s++) begin : g_side
			// shift stages: a test step wins over a software seed write in the same cycle
			always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
				if (SYS_RST_I) begin
					in_sh_ff[s] <= `BTO_CELL_RST;
					out_sh_ff[s] <= `BTO_CELL_RST;
				end else if (step) begin
					if (rcv == bto_pkg::bto_side_t'(s)) begin
						in_sh_ff[s] <= nxt_in;
						if (op == bto_pkg::BTO_OP_CCNT) begin
							out_sh_ff[s] <= nxt_carry;
						end
					end else begin
						out_sh_ff[s] <= nxt_out;
					end
				end else if (do_write && wr_hit && awaddr_ff == (s == 0 ? `BTO_ADDR_CELL_A : `BTO_ADDR_CELL_B)) begin
					in_sh_ff[s] <= wr_merge[7:0];
					out_sh_ff[s] <= wr_merge[15:8];
				end
			end

			// shadows follow on the fall; control cells never enter any algorithm
			always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
				if (SYS_RST_I) begin
					in_shd_ff[s] <= `BTO_CELL_RST;
					out_shd_ff[s] <= `BTO_CELL_RST;
				end else if (tck_fall && step_pend_ff) begin
					if (rcv == bto_pkg::bto_side_t'(s)) begin
						in_shd_ff[s] <= in_sh_ff[s];
					end else if (op != bto_pkg::BTO_OP_PSA16) begin
						out_shd_ff[s] <= out_sh_ff[s];
					end
				end
			end
		end
	endgenerate

	// a rise that stepped the cells arms the shadow copy on the next fall
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			step_pend_ff <= 1'b0;
		end else if (step) begin
			step_pend_ff <= 1'b1;
		end else if (tck_fall) begin
			step_pend_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// bypass register and serial output
	// ----------------------------------------
	// run test selects bypass, so the serial path is one bit long
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			bypass_ff <= 1'b0;
		end else if (tck_rise && capture_s) begin
			bypass_ff <= 1'b0;
		end else if (tck_rise && shift_s) begin
			bypass_ff <= tdi_s;
		end
	end

	// serial output moves only on the falling test clock
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			tdo_ff <= 1'b0;
		end else if (tck_fall) begin
			tdo_ff <= bypass_ff;
		end
	end

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	assign TDO_O = tdo_ff;
	assign A_SIDE_PINS_O = out_shd_ff[0];
	assign B_SIDE_PINS_O = out_shd_ff[1];
	assign A_SIDE_PINS_OE_N_O = oe_n_ff[0];
	assign B_SIDE_PINS_OE_N_O = oe_n_ff[1];
	assign A_SIDE_LOGIC_O = in_shd_ff[0];
	assign B_SIDE_LOGIC_O = in_shd_ff[1];

	// ----------------------------------------
	// bus slave: write channels
	// ----------------------------------------
	// address and data are held separately, so either may arrive first
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			awaddr_ff <= 8'h00;
			aw_full_ff <= 1'b0;
		end else if (AWVALID_I && AWREADY_O) begin
			awaddr_ff <= AWADDR_I;
			aw_full_ff <= 1'b1;
		end else if (do_write) begin
			aw_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			w_full_ff <= 1'b0;
		end else if (WVALID_I && WREADY_O) begin
			wdata_ff <= WDATA_I;
			wstrb_ff <= WSTRB_I;
			w_full_ff <= 1'b1;
		end else if (do_write) begin
			w_full_ff <= 1'b0;
		end
	end

	assign AWREADY_O = ~aw_full_ff & ~bvalid_ff;
	assign WREADY_O = ~w_full_ff & ~bvalid_ff;
	assign do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
	assign wr_hit = (awaddr_ff == `BTO_ADDR_CTRL) || (awaddr_ff == `BTO_ADDR_DIR) ||
		(awaddr_ff == `BTO_ADDR_CELL_A) || (awaddr_ff == `BTO_ADDR_CELL_B);

	// byte strobes merge new data over the current register word
	always_comb begin
		wr_merge = rd_word;
		for (int b = 0; b < 4; b++) begin
			if (wstrb_ff[b]) begin
				wr_merge[b*8 +: 8] = wdata_ff[b*8 +: 8];
			end
		end
	end

	// write response; status and shadow words are read only and answer an error
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `BTO_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? `BTO_RESP_OKAY : `BTO_RESP_SLVERR;
		end else if (BREADY_I) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign BVALID_O = bvalid_ff;
	assign BRESP_O = bresp_ff;

	// control and direction words
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ctrl_ff <= `BTO_CTRL_RST;
			oe_n_ff <= `BTO_DIR_RST;
		end else if (do_write && awaddr_ff == `BTO_ADDR_CTRL) begin
			ctrl_ff <= wr_merge[`BTO_CTRL_W-1:0];
		end else if (do_write && awaddr_ff == `BTO_ADDR_DIR) begin
			oe_n_ff <= wr_merge[1:0];
		end
	end

	// ----------------------------------------
	// bus slave: read channels
	// ----------------------------------------
	// one word mux shared by reads and by write merging
	always_comb begin
		rd_hit = 1'b1;
		case (do_write ? awaddr_ff : ARADDR_I)
			`BTO_ADDR_CTRL: rd_word = {21'h00_0000, ctrl_ff};
			`BTO_ADDR_DIR: rd_word = {30'h0000_0000, oe_n_ff};
			`BTO_ADDR_CELL_A: rd_word = {16'h0000, out_sh_ff[0], in_sh_ff[0]};
			`BTO_ADDR_CELL_B: rd_word = {16'h0000, out_sh_ff[1], in_sh_ff[1]};
			`BTO_ADDR_STATUS: rd_word = {23'h00_0000, op, step_pend_ff, ~one_dir, run_ok, drv};
			`BTO_ADDR_SHADOW: rd_word = {out_shd_ff[1], in_shd_ff[1], out_shd_ff[0], in_shd_ff[0]};
			default: begin
				rd_word = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// a write in the same cycle borrows the mux, so the read waits one cycle
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `BTO_RESP_OKAY;
		end else if (ARVALID_I && ARREADY_O) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= rd_word;
			rresp_ff <= rd_hit ? `BTO_RESP_OKAY : `BTO_RESP_SLVERR;
		end else if (RREADY_I) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign ARREADY_O = ~rvalid_ff & ~do_write;
	assign RVALID_O = rvalid_ff;
	assign RDATA_O = rdata_ff;
	assign RRESP_O = rresp_ff;

endmodule

// >>> sim/bto_engine_chk.sv
`timescale 1ns/1ps

module bto_engine_chk (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic AWVALID_I,
	input wire logic AWREADY_O,
	input wire logic WVALID_I,
	input wire logic WREADY_O,
	input wire logic [1:0] BRESP_O,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	input wire logic TCK_I,
	input wire logic TDO_O,
	input wire logic [7:0] A_SIDE_PINS_O,
	input wire logic [7:0] B_SIDE_PINS_O,
	input wire logic A_SIDE_PINS_OE_N_O,
	input wire logic B_SIDE_PINS_OE_N_O
);
	// ----
	// bus handshakes
	// ----
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	// answers stand until the master takes them
	a_bresp_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
		else $error("write answer dropped early");
	a_rdata_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
		else $error("read answer dropped early");
	a_aw_blocked: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
		else $error("write taken while answer pending");
	a_wr_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##[1:2] BVALID_O)
		else $error("write answer late");
	a_rd_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read answer late");

	// ----
	// test clock side
	// ----
	// pins and serial out move only while the test clock is low
	a_pins_fall: assert property (!$stable({A_SIDE_PINS_O, B_SIDE_PINS_O}) |-> !$past(TCK_I, 2))
		else $error("pins moved outside low phase");
	a_tdo_fall: assert property (!$stable(TDO_O) |-> !$past(TCK_I, 2))
		else $error("serial out moved outside low phase");
	a_bypass_hold: assert property ((A_SIDE_PINS_OE_N_O == B_SIDE_PINS_OE_N_O) [*2] |->
		$stable(A_SIDE_PINS_O) && $stable(B_SIDE_PINS_O))
		else $error("pins moved with equal enables");
endmodule

bind bto_engine bto_engine_chk bto_engine_chk_inst (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
	.AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
	.BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
	.ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
	.TCK_I(TCK_I), .TDO_O(TDO_O), .A_SIDE_PINS_O(A_SIDE_PINS_O), .B_SIDE_PINS_O(B_SIDE_PINS_O),
	.A_SIDE_PINS_OE_N_O(A_SIDE_PINS_OE_N_O), .B_SIDE_PINS_OE_N_O(B_SIDE_PINS_OE_N_O));

// >>> sim/bto_tap_model.sv
`timescale 1ns/1ps

module bto_tap_model (
	output logic tck_o,
	output logic tdi_o,
	output logic run_instr_o,
	output logic run_idle_o,
	output logic capture_o,
	output logic shift_o,
	input wire logic tdo_i
);
	// ----
	// controller state
	// ----
	// test clock stands low between runs; serial in idles high as if pulled up
	initial begin
		tck_o = 1'b0;
		tdi_o = 1'b1;
		run_instr_o = 1'b0;
		run_idle_o = 1'b0;
		capture_o = 1'b0;
		shift_o = 1'b0;
	end

	// one period; serial out taken at the rise
	task automatic pulse(output logic s);
		#80;
		tck_o = 1'b1;
		s = tdo_i;
		#80;
		tck_o = 1'b0;
	endtask

	// flags move only while the clock is low
	task automatic run(input logic instr, input int n);
		logic s;
		#3;
		run_instr_o = instr;
		run_idle_o = 1'b1;
		repeat (n) pulse(s);
		#80;
		run_instr_o = 1'b0;
		run_idle_o = 1'b0;
	endtask

	// capture then shift three bits, first bit is bit 0
	task automatic scan(input logic [2:0] din, output logic [2:0] dout);
		logic s;
		#3;
		capture_o = 1'b1;
		pulse(s);
		capture_o = 1'b0;
		shift_o = 1'b1;
		for (int i = 0; i < 3; i++) begin
			tdi_o = din[i];
			pulse(dout[i]);
		end
		shift_o = 1'b0;
		tdi_o = 1'b1;
		#80;
	endtask
endmodule

// >>> sim/boundary_test_operation_engine_test.sv
`timescale 1ns/1ps
`include "bto_cfg.svh"

module boundary_test_operation_engine_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, a_pins = 8'h00, b_pins = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic aw_rdy, w_rdy, bvalid, ar_rdy, rvalid, tdo, tck, tdi, r_instr, r_idle, cap, shf, a_oe_n, b_oe_n;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, d32;
	logic [7:0] a_out, b_out, a_log, b_log, p, q;
	logic [15:0] c;
	logic [2:0] so;
	int errors = 0, cmp_count = 0, cyc = 0;

	always #5 clk = ~clk;

	bto_engine bto_engine_inst (.CLK_I(clk), .SYS_RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(aw_rdy), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(w_rdy),
		.BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
		.ARREADY_O(ar_rdy), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.TCK_I(tck), .TDI_I(tdi), .TDO_O(tdo), .RUN_BOUNDARY_TEST_INSTRUCTION_I(r_instr),
		.RUN_IDLE_I(r_idle), .CAPTURE_DR_I(cap), .SHIFT_DR_I(shf), .A_SIDE_PINS_I(a_pins),
		.B_SIDE_PINS_I(b_pins), .A_SIDE_PINS_O(a_out), .B_SIDE_PINS_O(b_out), .A_SIDE_PINS_OE_N_O(a_oe_n),
		.B_SIDE_PINS_OE_N_O(b_oe_n), .A_SIDE_LOGIC_O(a_log), .B_SIDE_LOGIC_O(b_log));
	bto_tap_model bto_tap_model_inst (.tck_o(tck), .tdi_o(tdi), .run_instr_o(r_instr), .run_idle_o(r_idle),
		.capture_o(cap), .shift_o(shf), .tdo_i(tdo));

	// ----
	// helpers
	// ----
	function automatic logic [15:0] l16(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic logic [7:0] l8(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// address and data offered together, each dropped once taken; answer ready comes late so the
	// slave must hold its answer for a cycle
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic ta, tw, hb, sb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			#1;
			ta = awvalid && aw_rdy;
			tw = wvalid && w_rdy;
			hb = bvalid && bready;
			sb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (hb) bready <= 1'b0;
			else if (sb) bready <= 1'b1;
		end while (!hb);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, hr, sv;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			#1;
			ta = arvalid && ar_rdy;
			hr = rvalid && rready;
			sv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (hr) rready <= 1'b0;
			else if (sv) rready <= 1'b1;
		end while (!hr);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, ed);
		chk(32'(r), 32'(er));
	endtask

	task automatic go(input logic instr, input int n);
		bto_tap_model_inst.run(instr, n);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rdchk(`BTO_ADDR_DIR, 32'h0000_0003, `BTO_RESP_OKAY);
		chk(32'({a_oe_n, b_oe_n, a_out, b_out}), 32'h0003_0000);
		rd(`BTO_ADDR_STATUS, d32, rsp);
		chk(d32 & 32'h0000_01F4, 32'h0000_0014);
		rdchk(8'h18, 32'h0000_0000, `BTO_RESP_SLVERR);
		w(`BTO_ADDR_STATUS, 32'h0000_0001, 4'hF, rsp);
		chk(32'(rsp), 32'(`BTO_RESP_SLVERR));
		w(`BTO_ADDR_CTRL, 32'h0000_FFFF, 4'h1, rsp);
		rdchk(`BTO_ADDR_CTRL, 32'h0000_00FF, `BTO_RESP_OKAY);
		$display("reset and bus test done");
	endtask

	task automatic t_toggle;
		w(`BTO_ADDR_DIR, 32'h0000_0000, 4'hF, rsp);
		w(`BTO_ADDR_CELL_B, 32'h0000_5A00, 4'hF, rsp);
		w(`BTO_ADDR_CTRL, 32'h0000_0004, 4'hF, rsp);
		a_pins <= 8'h3C;
		go(1'b1, 1);
		chk(32'({a_oe_n, b_oe_n, b_out}), 32'h0000_0000);
		w(`BTO_ADDR_DIR, 32'h0000_0001, 4'hF, rsp);
		go(1'b0, 1);
		chk(32'(b_out), 32'h0000_0000);
		go(1'b1, 1);
		chk(32'({a_oe_n, b_oe_n, b_out, a_log}), 32'h0002_A53C);
		go(1'b1, 1);
		chk(32'(b_out), 32'h0000_005A);
		$display("toggle test done");
	endtask

	task automatic t_sixteen;
		w(`BTO_ADDR_CELL_A, 32'h0000_0000, 4'hF, rsp);
		w(`BTO_ADDR_CELL_B, 32'h0000_0100, 4'hF, rsp);
		w(`BTO_ADDR_CTRL, 32'h0000_0001, 4'hF, rsp);
		go(1'b1, 2);
		c = l16(l16(16'h0100));
		chk(32'({b_out, a_log}), 32'(c));
		p = c[15:8];
		// upper four pins masked, so only the low nibble folds in
		w(`BTO_ADDR_CELL_A, 32'h0000_0011, 4'hF, rsp);
		w(`BTO_ADDR_CELL_B, 32'h0000_8000, 4'hF, rsp);
		w(`BTO_ADDR_CTRL, 32'h0000_0782, 4'hF, rsp);
		a_pins <= 8'hFF;
		go(1'b1, 2);
		c = l16(16'h8011) ^ 16'h000F;
		c = l16(c) ^ 16'h000F;
		chk(32'({b_out, a_log}), 32'({p, c[7:0]}));
		rdchk(`BTO_ADDR_CELL_B, 32'({c[15:8], 8'h00}), `BTO_RESP_OKAY);
		w(`BTO_ADDR_CELL_A, 32'h0000_0000, 4'hF, rsp);
		w(`BTO_ADDR_CELL_B, 32'h0000_0000, 4'hF, rsp);
		w(`BTO_ADDR_CTRL, 32'h0000_0001, 4'hF, rsp);
		go(1'b1, 2);
		chk(32'({b_out, a_log}), 32'h0000_0000);
		$display("sixteen bit test done");
	endtask

	task automatic t_eight;
		w(`BTO_ADDR_DIR, 32'h0000_0002, 4'hF, rsp);
		w(`BTO_ADDR_CELL_A, 32'h0000_0100, 4'hF, rsp);
		w(`BTO_ADDR_CELL_B, 32'h0000_0003, 4'hF, rsp);
		w(`BTO_ADDR_CTRL, 32'h0000_0003, 4'hF, rsp);
		b_pins <= 8'h81;
		go(1'b1, 3);
		p = 8'h01;
		q = 8'h03;
		repeat (3) begin
			p = l8(p);
			q = l8(q) ^ 8'h81;
		end
		chk(32'({a_oe_n, b_oe_n, a_out, b_log}), 32'({2'b01, p, q}));
		// counter two steps short of wrapping so the carry reaches the far cells
		w(`BTO_ADDR_CELL_A, 32'h0000_FE00, 4'hF, rsp);
		w(`BTO_ADDR_CELL_B, 32'h0000_0000, 4'hF, rsp);
		w(`BTO_ADDR_CTRL, 32'h0000_0007, 4'hF, rsp);
		b_pins <= 8'h00;
		go(1'b1, 2);
		chk(32'({a_out, b_log}), 32'h0000_0000);
		rdchk(`BTO_ADDR_CELL_B, 32'h0000_0100, `BTO_RESP_OKAY);
		$display("eight bit test done");
	endtask

	task automatic t_scan;
		bto_tap_model_inst.scan(3'b101, so);
		chk(32'(so), 32'h0000_0002);
		$display("serial test done");
	endtask

	// ----
	// run control
	// ----
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			end_of_test;
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_toggle;
		t_sixteen;
		t_eight;
		t_scan;
		end_of_test;
	end
endmodule
